// [hw/ssp_core.sv]
// Synchronous serial port core with APB register access
// Overview of operation
// - Each transfer shifts the outgoing byte out and incoming byte in together.
// - Serial clock is driven as master and taken as input as slave.
// - Master emits exactly eight clock pulses; clock idles outside transfers.
// - Slave ignores clock and data while select is high.
// - Data changes on one clock edge and is sampled on the opposite edge.
// - Phase 0: polarity sets idle level; shift on trailing, sample on leading edge.
// - Phase 0 master: data write starts; first bit out half period early.
// - Phase 1: shift on leading edge, sample on trailing edge.
// - Phase 1 master: data write starts; first bit out at the write, unchanged at first edge.
// - Bit order control selects MSB first or LSB first.
// - Phase 0 slave: data write while select low is rejected, sets collision.
// - Phase 1 slave: data writes accepted regardless of select when idle.
// - Transfer complete flag sets after the eighth shift cycle.
// - Single-buffered data register; shift register holds received byte at end.
// - Write during transfer sets collision flag and is discarded.
// - Slave receiving with previous byte unread sets overflow, overwrites data.
// - Interrupt request raised when complete flag goes from 0 to 1.
// - Master drives master-out; slave drives master-in.
// - Slave master-in driven while enabled, released when disabled.
// - Phase at control bit 2, polarity at bit 3, register index 2AH.
// - Master clock is pclk divided by 4, 8, 16 or 64 per rate code.
// - Bit order 0 sends bit 7 first, 1 sends bit 0 first.
// - Flags clear after flags read followed by data access; master mode also clears overflow.
// - In master mode overflow flag reads 0.
`timescale 1ns/10ps
`include "ssp_cfg.svh"

module ssp_core (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial clock pin
   input  wire logic        sclk_in,
   output logic             sclk_out,
   output logic             sclk_oe,
   // Master-out pin
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe,
   // Master-in pin
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe,
   // Active-low select pin
   input  wire logic        ss_n_in,
   // Interrupt request
   output logic             transfer_irq
);

   // ****************************************
   // Registers and synchronisers
   // ****************************************
   logic [6:0]  ctrl_q;
   logic [7:0]  shift_q;
   logic [7:0]  rdata_q;
   logic        tc_q, write_collision_flag_q, ovf_q, armed_q, irq_q;
   logic [3:0]  bits_q;
   logic [6:0]  div_q;
   logic        sck_q;
   logic        m_samp_q;
   logic        mout_q, sout_q;
   logic [2:0]  sclk_s, ss_s, mosi_s, miso_s;
   logic        sclk_prev_q;
   ssp_pkg::ssp_state_t state_q;

   // ****************************************
   // Decode
   // ****************************************
   wire acc       = psel && penable;
   wire wr        = acc && pwrite;
   wire rd        = acc && !pwrite;
   wire hit_ctrl  = paddr == `SSP_CTRL_ADDR;
   wire hit_flags = paddr == `SSP_FLAGS_ADDR;
   wire hit_data  = paddr == `SSP_DATA_ADDR;
   wire mapped    = hit_ctrl || hit_flags || hit_data;
   wire cpha      = ctrl_q[`SSP_CPHA_BIT];
   wire cpol      = ctrl_q[`SSP_CPOL_BIT];
   wire master    = ctrl_q[`SSP_MASTER_SELECT_BIT];
   wire lsb_first = ctrl_q[`SSP_BOS_BIT];
   wire enable    = ctrl_q[`SSP_EN_BIT];
   wire busy      = state_q != ssp_pkg::SSP_IDLE;

   // Synchronised pins, read only from the second stage onward
   wire sclk_sync = sclk_s[1];
   wire ss_n_sync = ss_s[1];
   wire mosi_sync = mosi_s[1];
   wire miso_sync = miso_s[1];

   // Bit presented on the outgoing line
   function automatic logic out_bit(input logic [7:0] v, input logic lsb);
      out_bit = lsb ? v[0] : v[7];
   endfunction : out_bit

   // Shift in a bit at the end opposite the outgoing one
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb,
                                           input logic b);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction : shift_in

   // Half period selection from rate code
   logic [6:0] half_cnt;
   always_comb begin
      case (ctrl_q[`SSP_RATE_HI:`SSP_RATE_LO])
         2'b00:   half_cnt = `SSP_HALF_DIV4;
         2'b01:   half_cnt = `SSP_HALF_DIV8;
         2'b10:   half_cnt = `SSP_HALF_DIV16;
         default: half_cnt = `SSP_HALF_DIV64;
      endcase
   end

   // Data write acceptance
   wire data_wr    = wr && hit_data;
   wire slave_lock = !master && !cpha && !ss_n_sync;
   wire wr_reject  = data_wr && (busy || slave_lock);
   wire wr_accept  = data_wr && !wr_reject;
   wire mstart     = wr_accept && master && enable;

   // Slave edge detection on synchronised serial clock
   wire s_sel   = enable && !master && !ss_n_sync;
   wire s_rise  = sclk_sync && !sclk_prev_q;
   wire s_fall  = !sclk_sync && sclk_prev_q;
   wire s_lead  = s_sel && (cpol ? s_fall : s_rise);
   wire s_trail = s_sel && (cpol ? s_rise : s_fall);
   wire s_samp  = cpha ? s_trail : s_lead;
   wire s_shift = cpha ? s_lead : s_trail;

   // Master edges at end of each half period
   wire half_done = div_q == 7'h01;
   // Leading edges include the one that ends the lead-in half period
   wire m_lead    = (state_q == ssp_pkg::SSP_SHIFT || state_q == ssp_pkg::SSP_LEAD) &&
                    half_done && (sck_q == cpol);
   wire m_trail   = state_q == ssp_pkg::SSP_SHIFT && half_done && (sck_q != cpol);
   wire lead_go   = state_q == ssp_pkg::SSP_LEAD && half_done;
   wire m_samp    = cpha ? m_trail : m_lead;
   wire m_shift   = cpha ? m_lead : m_trail;

   // Master samples one cycle after its edge so the synchronised input has settled
   wire samp_ev   = master ? m_samp_q : s_samp;
   wire shift_ev  = master ? m_shift : s_shift;
   wire in_bit    = master ? miso_sync : mosi_sync;
   wire last_samp = samp_ev && bits_q == 4'h7;
   wire m_done    = master && (cpha ? (m_samp_q && bits_q == `SSP_BITS - 4'h1) :
                                      (m_trail && bits_q == `SSP_BITS));
   wire s_done    = !master && last_samp;
   wire done      = m_done || s_done;
   wire tc_set    = done;

   // Flag clearing sequence: flags read arms, data access clears
   wire flags_rd  = rd && hit_flags;
   wire clr_flags = acc && hit_data && armed_q;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s <= 3'h0;
         ss_s   <= 3'h7;
         mosi_s <= 3'h0;
         miso_s <= 3'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk_in};
         ss_s   <= {ss_s[1:0], ss_n_in};
         mosi_s <= {mosi_s[1:0], mosi_in};
         miso_s <= {miso_s[1:0], miso_in};
      end
   end

   // Previous synchronised clock for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sclk_prev_q <= 1'b0;
      else          sclk_prev_q <= sclk_sync;
   end

   // Delayed master sample strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) m_samp_q <= 1'b0;
      else          m_samp_q <= m_samp;
   end

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                        ctrl_q <= 7'(`SSP_CTRL_RST);
      else if (wr && hit_ctrl && !busy)    ctrl_q <= 7'(pwdata[6:0] & 7'(`SSP_CTRL_MASK));
   end

   // ****************************************
   // Transfer state machine and clock divider
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ssp_pkg::SSP_IDLE;
         div_q   <= 7'h00;
         sck_q   <= 1'b0;
         bits_q  <= 4'h0;
      end else begin
         case (state_q)
            ssp_pkg::SSP_IDLE: begin
               sck_q  <= cpol;
               bits_q <= s_samp ? 4'h1 : 4'h0;
               div_q  <= half_cnt;
               if (mstart) state_q <= ssp_pkg::SSP_LEAD;
               else if (s_sel && (s_lead || s_trail)) state_q <= ssp_pkg::SSP_SHIFT;
            end
            ssp_pkg::SSP_LEAD: begin
               // Half period with data valid before the first edge
               div_q <= half_done ? half_cnt : div_q - 7'h01;
               if (lead_go) begin
                  state_q <= ssp_pkg::SSP_SHIFT;
                  sck_q   <= !cpol;
               end
            end
            ssp_pkg::SSP_SHIFT: begin
               if (master) begin
                  div_q <= half_done ? half_cnt : div_q - 7'h01;
                  if (half_done && !m_done) sck_q <= !sck_q;
                  if (m_samp_q) bits_q <= bits_q + 4'h1;
                  if (m_done) begin
                     state_q <= ssp_pkg::SSP_IDLE;
                     sck_q   <= cpol;
                  end
               end else begin
                  if (s_samp) bits_q <= bits_q + 4'h1;
                  if (s_done || ss_n_sync || !enable) state_q <= ssp_pkg::SSP_IDLE;
               end
            end
            default: state_q <= ssp_pkg::SSP_IDLE;
         endcase
      end
   end

   // ****************************************
   // Shift register and outgoing data
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= 8'h00;
         mout_q  <= 1'b0;
         sout_q  <= 1'b0;
      end else begin
         if (wr_accept) begin
            shift_q <= pwdata[7:0];
            mout_q  <= out_bit(pwdata[7:0], lsb_first);
            sout_q  <= out_bit(pwdata[7:0], lsb_first);
         end else if (samp_ev && busy || s_samp) begin
            shift_q <= shift_in(shift_q, lsb_first, in_bit);
         end else if (shift_ev && busy && !done) begin
            // Present next bit after the sample
            if (master) mout_q <= out_bit(shift_q, lsb_first);
            else        sout_q <= out_bit(shift_q, lsb_first);
         end else if (!busy && !master) begin
            // Idle slave shows its first bit before the first edge
            sout_q <= out_bit(shift_q, lsb_first);
         end
      end
   end

   // ****************************************
   // Received byte, flags and interrupt
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 8'h00;
         tc_q    <= 1'b0;
         write_collision_flag_q  <= 1'b0;
         ovf_q   <= 1'b0;
         armed_q <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         if (done) rdata_q <= samp_ev ? shift_in(shift_q, lsb_first, in_bit) : shift_q;
         // Set wins over the clearing sequence
         tc_q   <= tc_set || (tc_q && !clr_flags);
         write_collision_flag_q <= wr_reject || (write_collision_flag_q && !clr_flags);
         ovf_q  <= !master && ((s_done && tc_q) || (ovf_q && !clr_flags));
         if (flags_rd)       armed_q <= 1'b1;
         else if (clr_flags) armed_q <= 1'b0;
         irq_q  <= tc_set && !tc_q;
      end
   end

   // ****************************************
   // Read data, answer and pins
   // ****************************************
   wire [7:0] flags_v = {tc_q, write_collision_flag_q, ovf_q && !master, busy, 4'h0};
   wire [7:0] rsel    = hit_ctrl  ? {1'b0, ctrl_q} :
                        hit_flags ? flags_v :
                        hit_data  ? rdata_q : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)           prdata <= 32'h0000_0000;
      else if (psel && !penable) prdata <= {24'h00_0000, rsel};
   end

   assign pready       = 1'b1;
   assign pslverr      = acc && !mapped;
   assign sclk_out     = sck_q;
   assign sclk_oe      = enable && master;
   assign mosi_out     = mout_q;
   assign mosi_oe      = enable && master;
   assign miso_out     = sout_q;
   assign miso_oe      = enable && !master;
   assign transfer_irq = irq_q;

endmodule : ssp_core

// [include/ssp_cfg.svh]
// Constants of the synchronous serial port: offsets, fields, reset values
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// ****************************************
// Register byte offsets (APB, one word each)
// ****************************************
`define SSP_CTRL_IDX      8'h2A
`define SSP_CTRL_ADDR     12'h0A8
`define SSP_FLAGS_ADDR    12'h0AC
`define SSP_DATA_ADDR     12'h0B0
// ****************************************
// Control register fields
// ****************************************
`define SSP_RATE_LO       0
`define SSP_RATE_HI       1
`define SSP_CPHA_BIT      2
`define SSP_CPOL_BIT      3
`define SSP_MASTER_SELECT_BIT      4
`define SSP_BOS_BIT       5
`define SSP_EN_BIT        6
`define SSP_CTRL_RST      8'h00
`define SSP_CTRL_MASK     8'h7F
// ****************************************
// Flags register fields
// ****************************************
`define SSP_TC_BIT        7
`define SSP_WRITE_COLLISION_FLAG_BIT      6
`define SSP_OVF_BIT       5
`define SSP_BUSY_BIT      4
// ****************************************
// Timing: half periods of the serial clock in pclk cycles
// ****************************************
`define SSP_HALF_DIV4     7'h02
`define SSP_HALF_DIV8     7'h04
`define SSP_HALF_DIV16    7'h08
`define SSP_HALF_DIV64    7'h20
`define SSP_BITS          4'h8
`endif

// [include/ssp_pkg.sv]
// Types of the synchronous serial port
package ssp_pkg;
   typedef enum logic [2:0] {
      SSP_IDLE  = 3'b001,
      SSP_LEAD  = 3'b010,
      SSP_SHIFT = 3'b100
   } ssp_state_t;
endpackage : ssp_pkg

// [verif/ssp_core_asserts.sv]
// Concurrent checks on the serial port core ports
`timescale 1ns/10ps
`include "ssp_cfg.svh"

module ssp_core_asserts (
   // APB clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Serial pins and interrupt
   input wire logic        sclk_out,
   input wire logic        sclk_oe,
   input wire logic        mosi_oe,
   input wire logic        miso_oe,
   input wire logic        transfer_irq
);
   // ********************************
   // Helper logic
   // ********************************
   logic [4:0] edge_cnt_q;
   logic [2:0] ctrl_dly_q;
   logic       sclk_last_q;
   wire        ctrl_wr    = psel && penable && pwrite && paddr == `SSP_CTRL_ADDR;
   wire        sclk_edge  = sclk_oe && sclk_out != sclk_last_q;
   wire        cnt_clr    = transfer_irq || ctrl_wr || ctrl_dly_q != 3'h0;
   wire [4:0]  edge_cnt_d = cnt_clr ? 5'h00 : edge_cnt_q + {4'h0, sclk_edge};
   wire        mapped     = paddr inside {`SSP_CTRL_ADDR, `SSP_FLAGS_ADDR, `SSP_DATA_ADDR};
   // Count serial clock edges, idle-level moves after control writes excluded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_q  <= 5'h00;
         ctrl_dly_q  <= 3'h0;
         sclk_last_q <= 1'b0;
      end else begin
         edge_cnt_q  <= edge_cnt_d;
         ctrl_dly_q  <= {ctrl_dly_q[1:0], ctrl_wr};
         sclk_last_q <= sclk_out;
      end
   end
   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_slave_on;
      ctrl_wr && pwdata[6] && !pwdata[4];
   endsequence
   sequence s_drive_soon;
      ##[1:2] miso_oe;
   endsequence
   sequence s_rd_flags;
      psel && penable && !pwrite && paddr == `SSP_FLAGS_ADDR;
   endsequence
   chk_master_pins: assert property (sclk_oe == mosi_oe)
      else $error("clock and master-out enables differ");
   chk_miso_master: assert property (sclk_oe |-> !miso_oe)
      else $error("master-in driven in master mode");
   chk_slave_drive: assert property (s_slave_on |-> s_drive_soon)
      else $error("enabled slave leaves master-in undriven");
   chk_slave_float: assert property (ctrl_wr && !pwdata[6] |=> ##[0:1] !miso_oe)
      else $error("disabled port still drives master-in");
   chk_pulse_count: assert property (transfer_irq && sclk_oe |-> edge_cnt_d + 5'h00 == 5'h00 && edge_cnt_q + {4'h0, sclk_edge} == 5'h10)
      else $error("master transfer without sixteen clock edges");
   chk_half_period: assert property (sclk_oe && $changed(sclk_out) |=> $stable(sclk_out))
      else $error("serial clock half period below two cycles");
   chk_irq_pulse: assert property (transfer_irq |=> !transfer_irq)
      else $error("interrupt pulse longer than one cycle");
   chk_ovf_master: assert property (s_rd_flags ##0 sclk_oe |-> !prdata[5])
      else $error("overflow flag reads one in master mode");
   chk_unmapped: assert property (psel && penable |-> pslverr == !mapped)
      else $error("slave error does not match address map");
   chk_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
endmodule : ssp_core_asserts

// [verif/ssp_peer_model.sv]
// Behavioural serial slave answering the core in master mode
`timescale 1ns/10ps

module ssp_peer_model (
   // Serial lines
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   output logic            miso,
   // Format and data
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte
);
   logic [7:0] sh_q;
   // Load on select, first bit early in phase 0
   always @(negedge ss_n) begin
      sh_q = tx_byte;
      rx_byte = 8'h00;
      if (!cpha)
         miso = sh_q[7];
   end
   // Released line shows the inverse of its last level
   always @(posedge ss_n)
      miso = ~miso;
   // Sample on one edge, shift on the other
   always @(sclk) begin
      if (!ss_n && (sclk ^ cpol ^ cpha)) begin
         rx_byte = {rx_byte[6:0], mosi};
      end else if (!ss_n && !cpha) begin
         sh_q = sh_q << 1;
         miso = sh_q[7];
      end else if (!ss_n) begin
         miso = sh_q[7];
         sh_q = sh_q << 1;
      end
   end
endmodule : ssp_peer_model

// [verif/tb_top.sv]
// Self-checking bench of the serial port core
`timescale 1ns/10ps
`include "ssp_cfg.svh"

module tb_top;
   // ********************************
   // Signals and instances
   // ********************************
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic        tb_sclk = 1'b0, tb_mosi = 1'b0, ss_n = 1'b1, peer_cpol = 1'b0, peer_cpha = 1'b0;
   logic [7:0]  peer_tx = 8'h00, peer_rx;
   logic        err, pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe;
   logic        miso_out, miso_oe, transfer_irq, peer_miso;
   int          failures = 0, cmp_count = 0;
   wire         sclk_w = sclk_oe ? sclk_out : tb_sclk;
   wire         mosi_w = mosi_oe ? mosi_out : tb_mosi;
   wire         miso_w = miso_oe ? miso_out : peer_miso;
   // Clock
   always #2 pclk = ~pclk;
   ssp_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n), .transfer_irq(transfer_irq));
   ssp_peer_model u_peer (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_n), .miso(peer_miso),
      .cpol(peer_cpol), .cpha(peer_cpha), .tx_byte(peer_tx), .rx_byte(peer_rx));
   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_irq(input logic exp, output int n);
      n = 0;
      while (transfer_irq !== 1'b1 && n < (exp ? 3000 : 16)) begin
         @(posedge pclk);
         n++;
      end
      check({7'h00, transfer_irq}, {7'h00, exp});
   endtask : wait_irq
   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int k = 0; k < 8; k++)
         rev[k] = b[7 - k];
   endfunction : rev
   task automatic master_xfer(input logic [7:0] c, tx, back, input logic clash);
      int         n;
      logic [6:0] h;
      h = c[1] ? (c[0] ? `SSP_HALF_DIV64 : `SSP_HALF_DIV16) : (c[0] ? `SSP_HALF_DIV8 : `SSP_HALF_DIV4);
      peer_cpha <= c[2];
      peer_cpol <= c[3];
      peer_tx <= back;
      apb(1'b1, `SSP_CTRL_ADDR, {24'h0, c});
      repeat (4) @(posedge pclk);
      ss_n <= 1'b0;
      apb(1'b1, `SSP_DATA_ADDR, {24'h0, tx});
      if (clash)
         apb(1'b1, `SSP_DATA_ADDR, 32'h000000FF);
      wait_irq(1'b1, n);
      ss_n <= 1'b1;
      check({7'h00, n >= 16 * h - 4 && n <= 18 * h + 4}, 8'h01);
      check(peer_rx, c[5] ? rev(tx) : tx);
      apb(1'b0, `SSP_FLAGS_ADDR, 32'h0);
      check(rd[7:0] & 8'hE0, {1'b1, clash, 6'h00});
      apb(1'b0, `SSP_DATA_ADDR, 32'h0);
      check(rd[7:0], c[5] ? rev(back) : back);
      apb(1'b0, `SSP_FLAGS_ADDR, 32'h0);
      check(rd[7:0] & 8'hF0, 8'h00);
   endtask : master_xfer
   task automatic slave_byte(input logic [7:0] b, input logic sel, input logic irq,
                             output logic [7:0] got);
      int n;
      ss_n <= !sel;
      for (int k = 7; k >= 0; k--) begin
         repeat (8) @(posedge pclk);
         tb_sclk <= 1'b1;
         tb_mosi <= b[k];
         repeat (8) @(posedge pclk);
         got[k] = miso_w;
         tb_sclk <= 1'b0;
      end
      if (sel)
         wait_irq(irq, n);
      ss_n <= 1'b1;
      tb_mosi <= ~tb_mosi;
   endtask : slave_byte
   // ********************************
   // Scenarios
   // ********************************
   task automatic test_regs();
      apb(1'b0, `SSP_CTRL_ADDR, 32'h0);
      check(rd[7:0], `SSP_CTRL_RST);
      apb(1'b1, `SSP_CTRL_ADDR, 32'h0000000C);
      apb(1'b0, `SSP_CTRL_ADDR, 32'h0);
      check(rd[7:0], 8'h0C);
      apb(1'b0, 12'h0FC, 32'h0);
      check({err, rd[6:0]}, 8'h80);
   endtask : test_regs
   task automatic test_master_modes();
      for (int i = 0; i < 4; i++)
         master_xfer(8'h50 | {2'b00, i[0] ^ i[1], 1'b0, i[1:0], i[1:0]}, 8'hC5 ^ i[7:0], 8'h3A, 1'b0);
   endtask : test_master_modes
   task automatic test_collision();
      master_xfer(8'h50, 8'h96, 8'h69, 1'b1);
   endtask : test_collision
   task automatic test_slave();
      logic [7:0] g;
      apb(1'b1, `SSP_CTRL_ADDR, 32'h00000044);
      apb(1'b1, `SSP_DATA_ADDR, 32'h000000A5);
      check({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h01);
      slave_byte(8'h11, 1'b0, 1'b0, g);
      apb(1'b0, `SSP_FLAGS_ADDR, 32'h0);
      check(rd[7:0] & 8'hE0, 8'h00);
      slave_byte(8'h3C, 1'b1, 1'b1, g);
      check(g, 8'hA5);
      slave_byte(8'hC3, 1'b1, 1'b0, g);
      check(g, 8'h3C);
      apb(1'b0, `SSP_FLAGS_ADDR, 32'h0);
      check(rd[7:0] & 8'hE0, 8'hA0);
      apb(1'b0, `SSP_DATA_ADDR, 32'h0);
      check(rd[7:0], 8'hC3);
      apb(1'b1, `SSP_CTRL_ADDR, 32'h00000040);
      ss_n <= 1'b0;
      apb(1'b1, `SSP_DATA_ADDR, 32'h00000077);
      ss_n <= 1'b1;
      apb(1'b0, `SSP_FLAGS_ADDR, 32'h0);
      check(rd[7:0] & 8'hE0, 8'h40);
      apb(1'b1, `SSP_CTRL_ADDR, 32'h0);
      apb(1'b0, `SSP_CTRL_ADDR, 32'h0);
      check({6'h00, sclk_oe, miso_oe}, 8'h00);
   endtask : test_slave
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // Main sequence after reset
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_master_modes();
      test_collision();
      test_slave();
      test_done();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      test_done();
   end
endmodule : tb_top

bind ssp_core ssp_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
   .miso_oe(miso_oe), .transfer_irq(transfer_irq));
